/* shared/cpoc_pkg.sv */
package cpoc_pkg;
  // ==========================================
  // Timing
  localparam real CLK_PERIOD_NS = 20.0;
  localparam real RELEASE_DELAY_MS = 0.5;
  localparam real POWER_DOWN_MS = 10.0;
  localparam int RELEASE_CYC = int'($ceil(RELEASE_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int POWER_DOWN_CYC = int'($ceil(POWER_DOWN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int TIMER_W = 20;
  // ==========================================
  // Register map, byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BANK_START_OFS = 8'h04;
  localparam logic [7:0] END_ADDR_OFS = 8'h08;
  localparam logic [7:0] MEM_PTR_OFS = 8'h0c;
  localparam logic [7:0] MEM_DATA_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam int REG_OFS_W = 8;
  // ==========================================
  // Control bits
  localparam int CTRL_REV_EN_BIT = 0;
  localparam int CTRL_PAR_BIT = 1;
  localparam int CTRL_DECOMP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status bits above the address field
  localparam int STAT_CASCADE_BIT = 16;
  localparam int STAT_STANDBY_BIT = 17;
  localparam int STAT_HOLDING_BIT = 18;
  localparam int STAT_POWERED_BIT = 19;
  // ==========================================
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;
  // Power sequencing states
  typedef enum logic [1:0] {PWR_OFF, PWR_DELAY, PWR_ON} cpoc_pwr_t;
endpackage : cpoc_pkg

/* src/cpoc_top.sv */
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cpoc_top #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8,
  parameter int RELEASE_CYCLES = cpoc_pkg::RELEASE_CYC,
  parameter int POWER_DOWN_CYCLES = cpoc_pkg::POWER_DOWN_CYC
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Supply monitors, asynchronous
  input wire logic supply_ok,
  input wire logic core_power_down_threshold,
  // Configuration port pins, asynchronous
  input wire logic data_clock,
  input wire logic device_select_n,
  input wire logic config_pulse_n,
  input wire logic busy,
  input wire logic output_enable_reset_n_in,
  output logic output_enable_reset_n_out,
  output logic output_enable_reset_n_oe,
  // Stream outputs
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic forwarded_clock_out,
  output logic forwarded_clock_oe,
  output logic cascade_select_out_n,
  output logic low_power_standby,
  output logic reduced_current
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int TW = cpoc_pkg::TIMER_W;
  localparam logic [ADDR_W-1:0] TERMINAL_COUNT = ADDR_W'(DEPTH - 1);
  localparam logic [TW-1:0] REL_LAST = TW'(RELEASE_CYCLES - 1);
  localparam logic [TW-1:0] PD_LAST = TW'(POWER_DOWN_CYCLES - 1);

  // ==========================================
  // State
  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic clk_d;
    cpoc_pkg::cpoc_pwr_t pwr;
    logic [TW-1:0] rel_cnt;
    logic [TW-1:0] pd_cnt;
    logic [2:0] ctrl;
    logic [ADDR_W-1:0] bank_start;
    logic [ADDR_W-1:0] end_addr;
    logic [ADDR_W-1:0] mem_ptr;
    logic [DEPTH-1:0][DATA_W-1:0] mem;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic fclk;
    logic fclk_oe;
    logic cascade_n;
    logic standby;
    logic reduced;
    logic ap_valid;
    logic ap_write;
    logic [cpoc_pkg::REG_OFS_W-1:0] ap_ofs;
    logic rd_pend;
    logic [31:0] rdata;
  } cpoc_state_t;

  cpoc_state_t st_r;
  cpoc_state_t st_nxt;

  // Read-back value of one register; unmapped offsets read as zero
  function automatic logic [31:0] cpoc_read(input cpoc_state_t s, input logic [7:0] ofs);
    logic [31:0] v;
    v = '0;
    unique case (ofs)
      cpoc_pkg::CTRL_OFS: v[2:0] = s.ctrl;
      cpoc_pkg::BANK_START_OFS: v[ADDR_W-1:0] = s.bank_start;
      cpoc_pkg::END_ADDR_OFS: v[ADDR_W-1:0] = s.end_addr;
      cpoc_pkg::MEM_PTR_OFS: v[ADDR_W-1:0] = s.mem_ptr;
      cpoc_pkg::MEM_DATA_OFS: v[DATA_W-1:0] = s.mem[s.mem_ptr];
      cpoc_pkg::STATUS_OFS: begin
        v[ADDR_W-1:0] = s.addr;
        v[cpoc_pkg::STAT_CASCADE_BIT] = ~s.cascade_n;
        v[cpoc_pkg::STAT_STANDBY_BIT] = s.standby;
        v[cpoc_pkg::STAT_HOLDING_BIT] = s.reduced;
        v[cpoc_pkg::STAT_POWERED_BIT] = (s.pwr == cpoc_pkg::PWR_ON);
      end
      default: v = '0;
    endcase
    return v;
  endfunction : cpoc_read

  // Synchronised pin levels, taken from the second stage only
  logic sy_clk, sy_sel_n, sy_cf_n, sy_busy, sy_oer_n, sy_pwr_ok, sy_pd;
  assign {sy_pd, sy_pwr_ok, sy_oer_n, sy_busy, sy_cf_n, sy_sel_n, sy_clk} = st_r.s2;

  // ==========================================
  // Next state
  always_comb begin
    logic powered;
    logic enabled;
    logic clk_rise;
    logic busy_eff;
    logic rev_en;
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] limit;
    logic ap_take;
    powered = 1'b0;
    enabled = 1'b0;
    clk_rise = 1'b0;
    busy_eff = 1'b0;
    rev_en = 1'b0;
    start = '0;
    limit = '0;
    ap_take = 1'b0;
    st_nxt = st_r;
    // Two-flop synchronisers; the data clock gets a third flop for edges
    st_nxt.s1 = {core_power_down_threshold, supply_ok, output_enable_reset_n_in, busy,
                 config_pulse_n, device_select_n, data_clock};
    st_nxt.s2 = st_r.s1;
    st_nxt.clk_d = sy_clk;
    // Third flop reads only the second stage, so no metastable level reaches the edge
    clk_rise = sy_clk && !st_r.clk_d;

    // Power sequencing: reset pin held low until the release delay has run
    unique case (st_r.pwr)
      cpoc_pkg::PWR_OFF: begin
        st_nxt.rel_cnt = '0;
        if (sy_pwr_ok) begin
          st_nxt.pwr = cpoc_pkg::PWR_DELAY;
        end
      end
      cpoc_pkg::PWR_DELAY: begin
        st_nxt.rel_cnt = st_r.rel_cnt + TW'(1);
        if (st_r.rel_cnt == REL_LAST) begin
          st_nxt.pwr = cpoc_pkg::PWR_ON;
        end
      end
      cpoc_pkg::PWR_ON: st_nxt.rel_cnt = '0;
    endcase
    // Losing a supply restarts power-up, so the pin is pulled low again
    if (!sy_pwr_ok) begin
      st_nxt.pwr = cpoc_pkg::PWR_OFF;
    end
    // Brief dips are filtered; only a sustained drop forces full reset
    if (sy_pd) begin
      st_nxt.pd_cnt = (st_r.pd_cnt == PD_LAST) ? st_r.pd_cnt : st_r.pd_cnt + TW'(1);
      if (st_r.pd_cnt == PD_LAST) begin
        st_nxt.pwr = cpoc_pkg::PWR_OFF;
      end
    end else begin
      st_nxt.pd_cnt = '0;
    end

    // Address counter and output enables
    powered = (st_r.pwr == cpoc_pkg::PWR_ON);
    rev_en = st_r.ctrl[cpoc_pkg::CTRL_REV_EN_BIT];
    start = rev_en ? st_r.bank_start : '0;
    limit = rev_en ? st_r.end_addr : TERMINAL_COUNT;
    busy_eff = sy_busy && st_r.ctrl[cpoc_pkg::CTRL_PAR_BIT] &&
               !st_r.ctrl[cpoc_pkg::CTRL_DECOMP_BIT];
    enabled = powered && sy_oer_n && !sy_sel_n;
    st_nxt.standby = sy_sel_n;
    st_nxt.cascade_n = 1'b1;
    st_nxt.reduced = 1'b0;
    st_nxt.fclk = sy_clk;
    if (!enabled) begin
      st_nxt.addr = start;
      st_nxt.data_oe = 1'b0;
      st_nxt.fclk_oe = 1'b0;
    end else if (!sy_cf_n) begin
      st_nxt.addr = start;
      st_nxt.data_oe = 1'b1;
      st_nxt.fclk_oe = 1'b1;
    end else if (st_r.addr == TERMINAL_COUNT) begin
      st_nxt.cascade_n = 1'b0;
      st_nxt.reduced = 1'b1;
      st_nxt.data_oe = 1'b0;
      st_nxt.fclk_oe = 1'b0;
    end else if (st_r.addr == limit) begin
      st_nxt.reduced = 1'b1;
      st_nxt.data_oe = 1'b0;
      st_nxt.fclk_oe = 1'b0;
    end else begin
      st_nxt.data_oe = 1'b1;
      st_nxt.fclk_oe = 1'b1;
      if (clk_rise && !busy_eff) begin
        st_nxt.addr = st_r.addr + ADDR_W'(1);
      end
    end
    // Busy freezes the word on the pins as well as the counter
    if (!(enabled && busy_eff && sy_cf_n)) begin
      st_nxt.data = st_r.mem[st_nxt.addr];
    end

    // AHB-Lite: reads take one wait state so a preceding write is seen
    if (st_r.ap_valid && st_r.ap_write && hready) begin
      unique case (st_r.ap_ofs)
        cpoc_pkg::CTRL_OFS: st_nxt.ctrl = hwdata[2:0];
        cpoc_pkg::BANK_START_OFS: st_nxt.bank_start = hwdata[ADDR_W-1:0];
        cpoc_pkg::END_ADDR_OFS: st_nxt.end_addr = hwdata[ADDR_W-1:0];
        cpoc_pkg::MEM_PTR_OFS: st_nxt.mem_ptr = hwdata[ADDR_W-1:0];
        cpoc_pkg::MEM_DATA_OFS: begin
          st_nxt.mem[st_r.mem_ptr] = hwdata[DATA_W-1:0];
          st_nxt.mem_ptr = st_r.mem_ptr + ADDR_W'(1);
        end
        default: st_nxt.ctrl = st_r.ctrl;
      endcase
    end
    st_nxt.rd_pend = 1'b0;
    if (st_r.rd_pend) begin
      st_nxt.rdata = cpoc_read(st_r, st_r.ap_ofs);
    end
    if (hready) begin
      ap_take = hsel && (htrans == cpoc_pkg::HTRANS_NONSEQ || htrans == cpoc_pkg::HTRANS_SEQ);
      st_nxt.ap_valid = ap_take;
      st_nxt.ap_write = hwrite;
      st_nxt.ap_ofs = haddr[cpoc_pkg::REG_OFS_W-1:0];
      st_nxt.rd_pend = ap_take && !hwrite;
    end
  end


  // ==========================================
  // State register, frozen while the enable is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
      st_r.pwr <= cpoc_pkg::PWR_OFF;
      st_r.ctrl <= cpoc_pkg::CTRL_RESET;
      st_r.cascade_n <= 1'b1;
      st_r.standby <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign hrdata = st_r.rdata;
  assign hreadyout = !st_r.rd_pend;
  assign hresp = cpoc_pkg::HRESP_OKAY;
  assign output_enable_reset_n_out = 1'b0;
  assign output_enable_reset_n_oe = (st_r.pwr != cpoc_pkg::PWR_ON);
  assign data_out = st_r.data;
  assign data_oe = st_r.data_oe;
  assign forwarded_clock_out = st_r.fclk;
  assign forwarded_clock_oe = st_r.fclk_oe;
  assign cascade_select_out_n = st_r.cascade_n;
  assign low_power_standby = st_r.standby;
  assign reduced_current = st_r.reduced;
endmodule : cpoc_top
`default_nettype wire

/* tb/cpoc_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module cpoc_chk #(
  parameter int RELEASE_CYCLES = 20,
  parameter int POWER_DOWN_CYCLES = 30
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Supplies and control pins
  input wire logic supply_ok,
  input wire logic core_power_down_threshold,
  input wire logic device_select_n,
  input wire logic config_pulse_n,
  input wire logic output_enable_reset_n_in,
  input wire logic output_enable_reset_n_oe,
  // Stream side
  input wire logic data_oe,
  input wire logic forwarded_clock_oe,
  input wire logic cascade_select_out_n,
  input wire logic low_power_standby,
  input wire logic reduced_current
);
  // ==========================================
  // Helper counters: cycles the pin is held with good supplies, cycles below power-down
  logic [15:0] rel_cnt_r;
  logic [15:0] pd_cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rel_cnt_r <= 16'h0000;
      pd_cnt_r <= 16'h0000;
    end else begin
      rel_cnt_r <= (output_enable_reset_n_oe && supply_ok && !core_power_down_threshold) ?
                   rel_cnt_r + 16'h0001 : 16'h0000;
      pd_cnt_r <= core_power_down_threshold ? pd_cnt_r + 16'h0001 : 16'h0000;
    end
  end
  // ==========================================
  // Properties; async inputs get five cycles to pass the synchronisers
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence deselect_s; device_select_n [*5]; endsequence
  sequence pin_low_s; !output_enable_reset_n_in [*5]; endsequence
  sequence pulse_s;
    (!config_pulse_n && !device_select_n && output_enable_reset_n_in) [*5];
  endsequence
  sel_standby_a: assert property (deselect_s |-> low_power_standby)
    else $error("standby not entered");
  standby_hiz_a: assert property (low_power_standby |->
    !data_oe && !forwarded_clock_oe && cascade_select_out_n) else $error("standby outputs");
  pin_reset_a: assert property (pin_low_s |->
    !data_oe && !forwarded_clock_oe && cascade_select_out_n) else $error("pin reset outputs");
  cascade_hiz_a: assert property (!cascade_select_out_n |->
    !data_oe && !forwarded_clock_oe) else $error("cascade with driven outputs");
  reduced_hiz_a: assert property (reduced_current |->
    !data_oe && !forwarded_clock_oe) else $error("reduced with driven outputs");
  pwrup_drive_a: assert property (!supply_ok [*5] |-> output_enable_reset_n_oe)
    else $error("pin not driven low");
  release_delay_a: assert property ($fell(output_enable_reset_n_oe) |->
    rel_cnt_r >= RELEASE_CYCLES && rel_cnt_r <= RELEASE_CYCLES + 6) else $error("release time");
  pwr_down_a: assert property (pd_cnt_r == POWER_DOWN_CYCLES + 6 |->
    output_enable_reset_n_oe) else $error("no power-down reset");
  cfg_pulse_a: assert property (pulse_s |-> data_oe && cascade_select_out_n)
    else $error("pulse outputs");
endmodule : cpoc_chk
bind cpoc_top cpoc_chk #(
  .RELEASE_CYCLES(RELEASE_CYCLES),
  .POWER_DOWN_CYCLES(POWER_DOWN_CYCLES)
) cpoc_chk_inst (.hclk, .hresetn, .supply_ok, .core_power_down_threshold, .device_select_n,
  .config_pulse_n, .output_enable_reset_n_in, .output_enable_reset_n_oe, .data_oe,
  .forwarded_clock_oe, .cascade_select_out_n, .low_power_standby, .reduced_current);
`default_nettype wire

/* tb/cpoc_fpga_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpoc_fpga_model (
  // Frame and pin control from the bench
  input wire logic run,
  input wire logic hold_low,
  // Pins facing the device
  input wire logic output_enable_reset_n_oe,
  output logic data_clock,
  output logic output_enable_reset_n_in
);
  // Open-drain pin with pull-up; the host may hold it low until its supplies settle
  assign output_enable_reset_n_in = !(output_enable_reset_n_oe || hold_low);
  // Data clock only inside a frame, resting low between frames, phase offset from hclk
  // Test port lines are not modelled, so none is pulled low and no test clock runs
  initial begin
    data_clock = 1'b0;
    #3;
    forever #80 data_clock = run ? ~data_clock : 1'b0;
  end
endmodule : cpoc_fpga_model
`default_nettype wire

/* tb/tb_cpoc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cpoc_top;
  // ==========================================
  // Signals, named as the design ports
  localparam int REL = 20;
  localparam int PD = 30;
  logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic supply_ok, core_power_down_threshold, data_clock, device_select_n, config_pulse_n;
  logic busy, output_enable_reset_n_in, output_enable_reset_n_out, output_enable_reset_n_oe;
  logic [7:0] data_out;
  logic data_oe, forwarded_clock_out, forwarded_clock_oe, cascade_select_out_n;
  logic low_power_standby, reduced_current, run, hold_low;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  assign hready = hreadyout;
  cpoc_top #(.ADDR_W(4), .DATA_W(8), .RELEASE_CYCLES(REL), .POWER_DOWN_CYCLES(PD))
    cpoc_top_inst (.*);
  cpoc_fpga_model cpoc_fpga_model_inst (.run, .hold_low, .output_enable_reset_n_oe,
    .data_clock, .output_enable_reset_n_in);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // Hang guard: well above the under one thousand cycles the tests need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  // ==========================================
  // Tasks
  function automatic logic [7:0] pat(input int i);
    return 8'(i) ^ 8'h5a;
  endfunction : pat
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Single AHB transfer; read data lands in rd at the completing edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= cpoc_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", hresp, cpoc_pkg::HRESP_OKAY);
  endtask : ahb
  task automatic ck_st(input logic [3:0] a, input logic oe, input logic cs, input logic rc);
    ahb(1'b0, cpoc_pkg::STATUS_OFS, 32'h0);
    chk("address", rd[3:0], a);
    chk("data_oe", data_oe, oe);
    chk("cascade", cascade_select_out_n, cs);
    chk("reduced", reduced_current, rc);
  endtask : ck_st
  // A frame of n data clock rises, then let the synchronisers settle
  task automatic clocks(input int n);
    run = 1'b1;
    repeat (n) @(posedge data_clock);
    run = 1'b0;
    repeat (10) @(posedge hclk);
  endtask : clocks
  task automatic rst_addr();
    @(posedge hclk) config_pulse_n <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("pulse_oe", data_oe, 1'b1);
    config_pulse_n <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask : rst_addr
  task automatic wait_pin();
    while (output_enable_reset_n_in !== 1'b1) @(posedge hclk);
    repeat (4) @(posedge hclk);
  endtask : wait_pin
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  // ==========================================
  // Test sequence
  initial begin
    {hresetn, hwrite, busy, run, hold_low, core_power_down_threshold, device_select_n} = 7'h00;
    {clk_en, hsel, supply_ok, config_pulse_n} = 4'hf;
    {htrans, haddr, hwdata, hsize} = {2'h0, 64'h0, 3'h2};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (REL - 2) @(posedge hclk);
    chk("pin_oe", output_enable_reset_n_oe, 1'b1);
    chk("pin_out", output_enable_reset_n_out, 1'b0);
    wait_pin();
    ahb(1'b0, cpoc_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", rd, {29'h0, cpoc_pkg::CTRL_RESET});
    ahb(1'b1, 8'h3c, 32'hffffffff);
    ahb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b1, cpoc_pkg::MEM_PTR_OFS, 32'h0);
    for (int i = 0; i < 16; i++) ahb(1'b1, cpoc_pkg::MEM_DATA_OFS, {24'h0, pat(i)});
    $display("power-up and load done");
    rst_addr();
    ck_st(4'h0, 1'b1, 1'b1, 1'b0);
    clocks(5);
    chk("data", data_out, pat(5));
    chk("fclk_oe", forwarded_clock_oe, 1'b1);
    chk("fclk", forwarded_clock_out, 1'b0);
    clocks(12);
    ck_st(4'hf, 1'b0, 1'b0, 1'b1);
    $display("stream done");
    ahb(1'b1, cpoc_pkg::BANK_START_OFS, 32'h4);
    ahb(1'b1, cpoc_pkg::END_ADDR_OFS, 32'h6);
    ahb(1'b1, cpoc_pkg::CTRL_OFS, 32'h1);
    rst_addr();
    chk("data", data_out, pat(4));
    clocks(4);
    ck_st(4'h6, 1'b0, 1'b1, 1'b1);
    $display("revision done");
    ahb(1'b1, cpoc_pkg::CTRL_OFS, 32'h2);
    rst_addr();
    busy <= 1'b1;
    clocks(3);
    ck_st(4'h0, 1'b1, 1'b1, 1'b0);
    chk("data", data_out, pat(0));
    chk("fclk_oe", forwarded_clock_oe, 1'b1);
    ahb(1'b1, cpoc_pkg::CTRL_OFS, 32'h6);
    clocks(3);
    ck_st(4'h3, 1'b1, 1'b1, 1'b0);
    busy <= 1'b0;
    $display("busy done");
    device_select_n <= 1'b1;
    repeat (8) @(posedge hclk);
    chk("standby", low_power_standby, 1'b1);
    ck_st(4'h0, 1'b0, 1'b1, 1'b0);
    device_select_n <= 1'b0;
    clocks(2);
    hold_low <= 1'b1;
    repeat (8) @(posedge hclk);
    ck_st(4'h0, 1'b0, 1'b1, 1'b0);
    hold_low <= 1'b0;
    supply_ok <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("pin_oe", output_enable_reset_n_oe, 1'b1);
    supply_ok <= 1'b1;
    wait_pin();
    $display("standby and pin reset done");
    clocks(2);
    core_power_down_threshold <= 1'b1;
    repeat (PD - 4) @(posedge hclk);
    chk("pin_oe", output_enable_reset_n_oe, 1'b0);
    repeat (12) @(posedge hclk);
    chk("pin_oe", output_enable_reset_n_oe, 1'b1);
    core_power_down_threshold <= 1'b0;
    wait_pin();
    ck_st(4'h0, 1'b1, 1'b1, 1'b0);
    $display("power-down done");
    print_verdict();
  end
endmodule : tb_cpoc_top
`default_nettype wire
